// [logic/hbc_ctrl_regs.sv]
// Miscellaneous and buffer-RAM control register bank on the host command bus
//
// What this block does
// - Sixteen-bit scratch word, codes 28/A8, resets zero
// - Key F6H clears registers, buffer RAM kept
// - Soft reset reached only by write A9
// - One isochronous length sizes both iso buffers
// - Ack length register sizes acknowledged buffer
// - Status bits 0-2 give per-buffer full flags
// - Status bits 3-5 give per-buffer done flags
// - Status read-only at 2C, upper bits zero
// - Code 2D reports bytes waiting in iso zero
`timescale 1ns/100ps
`default_nettype none
module hbc_ctrl_regs
  import hbc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmdStrobe,
  input wire logic [7:0] cmdCode,
  input wire logic dataWrStrobe,
  input wire logic [HBC_DW-1:0] dataWrValue,
  input wire logic [HBC_BUF_N-1:0] bufFullIn,
  input wire logic [HBC_BUF_N-1:0] bufDoneIn,
  input wire logic [HBC_DW-1:0] iso0BytesIn,
  output var logic [HBC_DW-1:0] rdData_r,
  output var logic rdValid_r,
  output var logic [HBC_DW-1:0] isoBufLen_r,
  output var logic [HBC_DW-1:0] ackBufLen_r,
  output var logic softReset_r
);
  ////////////////////////////////////////////////////////////////////////////
  // Command latch: a write code arms exactly one following data word
  logic [7:0] wrCode_r;
  logic wrArmed_r;
  logic [7:0] wrCode_nxt;
  logic wrArmed_nxt;
  logic isWrCode;
  logic dataTaken;

  assign isWrCode = cmdCode[7];
  assign dataTaken = dataWrStrobe && wrArmed_r;
  assign wrCode_nxt = (cmdStrobe && isWrCode) ? cmdCode : wrCode_r;
  // A new command always decides the arming; a data word disarms it
  assign wrArmed_nxt = cmdStrobe ? isWrCode : (dataTaken ? 1'b0 : wrArmed_r);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrCode_r <= 8'h00;
      wrArmed_r <= 1'b0;
    end else begin
      wrCode_r <= wrCode_nxt;
      wrArmed_r <= wrArmed_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  logic wrScratch;
  logic wrIsoLen;
  logic wrAckLen;
  logic softKeyHit;
  logic [HBC_DW-1:0] scratch_r;

  assign wrScratch = dataTaken && (wrCode_r == HBC_WR_SCRATCH);
  assign wrIsoLen = dataTaken && (wrCode_r == HBC_WR_ISOLEN);
  assign wrAckLen = dataTaken && (wrCode_r == HBC_WR_ACKLEN);
  // Only the exact key counts; any other value is dropped silently
  assign softKeyHit = dataTaken && (wrCode_r == HBC_WR_SOFTRST)
    && (dataWrValue == HBC_SOFT_KEY);

  ////////////////////////////////////////////////////////////////////////////
  // Read/write words; the soft key clears them, buffer RAM is not touched
  hbc_reg16 #(.RESET_VAL(HBC_RESET_VAL)) u_scratch (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .softClr(softKeyHit),
    .wrEn(wrScratch),
    .wrData(dataWrValue),
    .value_r(scratch_r)
  );

  // Same value serves both isochronous buffers
  hbc_reg16 #(.RESET_VAL(HBC_RESET_VAL)) u_iso_len (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .softClr(softKeyHit),
    .wrEn(wrIsoLen),
    .wrData(dataWrValue),
    .value_r(isoBufLen_r)
  );

  // No range check: software must keep the sum inside the 4096-byte RAM
  hbc_reg16 #(.RESET_VAL(HBC_RESET_VAL)) u_ack_len (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .softClr(softKeyHit),
    .wrEn(wrAckLen),
    .wrData(dataWrValue),
    .value_r(ackBufLen_r)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status snapshots from the engine, cleared by the soft key
  logic [HBC_FLAG_N-1:0] bufFlags_r;
  logic [HBC_FLAG_N-1:0] bufFlags_nxt;
  logic [HBC_DW-1:0] iso0Bytes_r;
  logic [HBC_DW-1:0] iso0Bytes_nxt;
  logic [HBC_DW-1:0] stateWord;

  assign bufFlags_nxt = softKeyHit ? '0 : {bufDoneIn, bufFullIn};
  assign iso0Bytes_nxt = softKeyHit ? HBC_RESET_VAL : iso0BytesIn;
  // Reserved upper bits are hard zero
  assign stateWord = {{(HBC_DW-HBC_FLAG_N){1'b0}}, bufFlags_r};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bufFlags_r <= '0;
      iso0Bytes_r <= HBC_RESET_VAL;
    end else begin
      bufFlags_r <= bufFlags_nxt;
      iso0Bytes_r <= iso0Bytes_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; unknown and write-only codes answer zero
  logic isRdCmd;
  logic [HBC_DW-1:0] rdSel;

  assign isRdCmd = cmdStrobe && !isWrCode;
  assign rdSel = (cmdCode == HBC_RD_SCRATCH) ? scratch_r :
    (cmdCode == HBC_RD_ISOLEN) ? isoBufLen_r :
    (cmdCode == HBC_RD_ACKLEN) ? ackBufLen_r :
    (cmdCode == HBC_RD_STATE) ? stateWord :
    (cmdCode == HBC_RD_ISO0BYTES) ? iso0Bytes_r :
    HBC_RESET_VAL;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= HBC_RESET_VAL;
      rdValid_r <= 1'b0;
      softReset_r <= 1'b0;
    end else begin
      rdData_r <= isRdCmd ? rdSel : rdData_r;
      rdValid_r <= isRdCmd;
      softReset_r <= softKeyHit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_scratch_write: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wrScratch |=> scratch_r == $past(dataWrValue))
    else $error("scratch word did not take the written value");

  a_soft_clears: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    softKeyHit |=> (scratch_r == HBC_RESET_VAL) && (isoBufLen_r ==
    HBC_RESET_VAL) && (ackBufLen_r == HBC_RESET_VAL) && softReset_r
    && (bufFlags_r == '0))
    else $error("soft key did not clear the registers");

  a_nonkey_ignored: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (dataTaken && wrCode_r == HBC_WR_SOFTRST && dataWrValue != HBC_SOFT_KEY)
    |=> !softReset_r && $stable(scratch_r) && $stable(isoBufLen_r))
    else $error("non-key soft reset write changed state");

  a_softrst_noread: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (isRdCmd && cmdCode == (HBC_WR_SOFTRST & 8'h7f)) |=>
    rdValid_r && rdData_r == HBC_RESET_VAL)
    else $error("soft reset register answered a read");

  // The host model leaves a spare cycle between a write and the next read, and
  // nothing may touch the length in between
  a_isolen_read: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wrIsoLen ##1 (!wrIsoLen && !softKeyHit) ##1
    (isRdCmd && cmdCode == HBC_RD_ISOLEN)
    |=> rdData_r == $past(dataWrValue, 3))
    else $error("iso length read back wrong");

  a_acklen_write: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wrAckLen |=> ackBufLen_r == $past(dataWrValue))
    else $error("ack length did not take the written value");

  a_state_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (isRdCmd && cmdCode == HBC_RD_STATE) |=>
    rdData_r[HBC_ACK_FULL:HBC_ISO0_FULL] == $past(bufFlags_r[2:0]) &&
    rdData_r[HBC_ACK_DONE:HBC_ISO0_DONE] == $past(bufFlags_r[5:3]))
    else $error("buffer status flags misplaced");

  a_state_reserved: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (isRdCmd && cmdCode == HBC_RD_STATE) |=>
    rdData_r[HBC_DW-1:HBC_FLAG_N] == '0)
    else $error("reserved status bits not zero");

  a_flags_follow: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !softKeyHit |=> bufFlags_r == $past({bufDoneIn, bufFullIn}))
    else $error("status snapshot lags the engine");

  a_readback_len: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !softKeyHit ##1 (isRdCmd && cmdCode == HBC_RD_ISO0BYTES) |=>
    rdData_r == $past(iso0BytesIn, 2))
    else $error("iso zero readback length wrong");

  a_read_pulse: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rdValid_r |-> $past(isRdCmd))
    else $error("read answer without a read command");

  c_scratch_rw: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wrScratch ##[1:4] (isRdCmd && cmdCode == HBC_RD_SCRATCH));
  c_soft_reset: cover property (@(posedge clk_sys) disable iff (!rst_n)
    softKeyHit);
  c_state_full: cover property (@(posedge clk_sys) disable iff (!rst_n)
    (isRdCmd && cmdCode == HBC_RD_STATE && bufFlags_r != '0));
  c_bad_key: cover property (@(posedge clk_sys) disable iff (!rst_n)
    dataTaken && wrCode_r == HBC_WR_SOFTRST && !softKeyHit);
endmodule // hbc_ctrl_regs
`default_nettype wire

// [logic/hbc_reg16.sv]
// One read/write control word with a synchronous soft clear
`timescale 1ns/100ps
`default_nettype none
module hbc_reg16
  import hbc_pkg::*;
#(
  parameter logic [HBC_DW-1:0] RESET_VAL = HBC_RESET_VAL
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic softClr,
  input wire logic wrEn,
  input wire logic [HBC_DW-1:0] wrData,
  output var logic [HBC_DW-1:0] value_r
);
  logic [HBC_DW-1:0] value_nxt;

  // Soft clear outranks a write so a reset key always lands cleanly
  assign value_nxt = softClr ? RESET_VAL : (wrEn ? wrData : value_r);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= RESET_VAL;
    end else begin
      value_r <= value_nxt;
    end
  end
endmodule // hbc_reg16
`default_nettype wire

// [pkg/hbc_pkg.sv]
// Command codes, field positions and reset values of the buffer control bank
package hbc_pkg;
  localparam int HBC_DW = 16;
  localparam logic [7:0] HBC_RD_SCRATCH = 8'h28;
  localparam logic [7:0] HBC_WR_SCRATCH = 8'ha8;
  localparam logic [7:0] HBC_WR_SOFTRST = 8'ha9;
  localparam logic [7:0] HBC_RD_ISOLEN = 8'h2a;
  localparam logic [7:0] HBC_WR_ISOLEN = 8'haa;
  localparam logic [7:0] HBC_RD_ACKLEN = 8'h2b;
  localparam logic [7:0] HBC_WR_ACKLEN = 8'hab;
  localparam logic [7:0] HBC_RD_STATE = 8'h2c;
  localparam logic [7:0] HBC_RD_ISO0BYTES = 8'h2d;
  localparam logic [15:0] HBC_SOFT_KEY = 16'h00f6;
  localparam logic [15:0] HBC_RESET_VAL = 16'h0000;
  // Buffer status layout: full flags low, done flags above them
  localparam int HBC_ISO0_FULL = 0;
  localparam int HBC_ISO1_FULL = 1;
  localparam int HBC_ACK_FULL = 2;
  localparam int HBC_ISO0_DONE = 3;
  localparam int HBC_ISO1_DONE = 4;
  localparam int HBC_ACK_DONE = 5;
  localparam int HBC_FLAG_N = 6;
  localparam int HBC_BUF_N = 3;
endpackage

// [tb/hbc_ctrl_regs_tb.sv]
// Self-checking bench for the buffer control register bank
`timescale 1ns/100ps
`default_nettype none
module hbc_ctrl_regs_tb import hbc_pkg::*; ;
  logic clk_sys, rst_n, cmdStrobe, dataWrStrobe, rdValid_r, softReset_r, ok;
  logic [7:0] cmdCode;
  logic [HBC_DW-1:0] dataWrValue, iso0BytesIn, rdData_r, v;
  logic [HBC_DW-1:0] isoBufLen_r, ackBufLen_r;
  logic [HBC_BUF_N-1:0] bufFullIn, bufDoneIn;
  int n_fail, samples_checked, pulses, p;
  hbc_ctrl_regs i_hbc_ctrl_regs (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmdStrobe(cmdStrobe), .cmdCode(cmdCode), .dataWrStrobe(dataWrStrobe),
    .dataWrValue(dataWrValue), .bufFullIn(bufFullIn),
    .bufDoneIn(bufDoneIn), .iso0BytesIn(iso0BytesIn), .rdData_r(rdData_r),
    .rdValid_r(rdValid_r), .isoBufLen_r(isoBufLen_r),
    .ackBufLen_r(ackBufLen_r), .softReset_r(softReset_r));
  hbc_host_model i_hbc_host_model (.clk_sys(clk_sys), .rdData_r(rdData_r),
    .rdValid_r(rdValid_r), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
    .dataWrStrobe(dataWrStrobe), .dataWrValue(dataWrValue));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a count of cycles with the soft reset pulse high
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (softReset_r === 1'b1) pulses++;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // A read must answer with the valid pulse as well as the word
  task automatic rdchk(logic [7:0] c, logic [15:0] e, string n);
    i_hbc_host_model.rd(c, v, ok);
    chk("read valid", 16'h0001, {15'h0000, ok});
    chk(n, e, v);
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("iso length", 16'h0000, isoBufLen_r);
    rdchk(HBC_RD_SCRATCH, 16'h0000, "scratch");
    rdchk(HBC_RD_STATE, 16'h0000, "status");
    rdchk(HBC_RD_ISO0BYTES, 16'h0000, "readback");
  endtask
  // Scratch round trip, no read code for the key, status not writable
  task automatic t_scratch();
    i_hbc_host_model.wr(HBC_WR_SCRATCH, 16'h5a3c);
    i_hbc_host_model.wr(8'hac, 16'h003f);
    rdchk(HBC_RD_SCRATCH, 16'h5a3c, "scratch");
    rdchk(8'h29, 16'h0000, "key read");
    rdchk(HBC_RD_STATE, 16'h0000, "status");
  endtask
  // Lengths fill the shared RAM exactly: 800h plus twice 400h
  task automatic t_lengths();
    i_hbc_host_model.wr(HBC_WR_ISOLEN, 16'h0400);
    i_hbc_host_model.wr(HBC_WR_ACKLEN, 16'h0800);
    // The data edge has only just launched the new length
    #1;
    chk("iso length", 16'h0400, isoBufLen_r);
    chk("ack length", 16'h0800, ackBufLen_r);
    rdchk(HBC_RD_ISOLEN, 16'h0400, "iso length");
    rdchk(HBC_RD_ACKLEN, 16'h0800, "ack length");
  endtask
  // Walk a single flag through every status bit
  task automatic t_status();
    for (int i = 0; i < HBC_FLAG_N; i++) begin
      @(posedge clk_sys);
      {bufDoneIn, bufFullIn} <= 6'h01 << i;
      repeat (2) @(posedge clk_sys);
      rdchk(HBC_RD_STATE, 16'h0001 << i, "status");
    end
    @(posedge clk_sys);
    iso0BytesIn <= 16'h0123;
    {bufDoneIn, bufFullIn} <= 6'h00;
    repeat (2) @(posedge clk_sys);
    rdchk(HBC_RD_ISO0BYTES, 16'h0123, "readback");
  endtask
  // A near-miss key changes nothing; the true key clears the bank
  task automatic t_key();
    p = pulses;
    i_hbc_host_model.wr(HBC_WR_SOFTRST, 16'hf6f6);
    repeat (2) @(posedge clk_sys);
    chk("pulses", 16'(p), 16'(pulses));
    chk("iso length", 16'h0400, isoBufLen_r);
    i_hbc_host_model.wr(HBC_WR_SOFTRST, HBC_SOFT_KEY);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("pulses", 16'(p + 1), 16'(pulses));
    chk("ack length", 16'h0000, ackBufLen_r);
    rdchk(HBC_RD_SCRATCH, 16'h0000, "scratch");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs a few hundred cycles at most
  initial begin
    #40000;
    n_fail++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    bufFullIn = 3'h0;
    bufDoneIn = 3'h0;
    iso0BytesIn = 16'h0000;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_scratch();
    t_lengths();
    t_status();
    t_key();
    close_out();
  end
endmodule // hbc_ctrl_regs_tb
`default_nettype wire

// [tb/hbc_host_model.sv]
// Microprocessor model that drives the command/data host bus
`timescale 1ns/100ps
`default_nettype none
module hbc_host_model
  import hbc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [HBC_DW-1:0] rdData_r,
  input wire logic rdValid_r,
  output var logic cmdStrobe,
  output var logic [7:0] cmdCode,
  output var logic dataWrStrobe,
  output var logic [HBC_DW-1:0] dataWrValue
);
  // Idle bus at time zero
  initial begin
    cmdStrobe = 1'b0;
    cmdCode = 8'h00;
    dataWrStrobe = 1'b0;
    dataWrValue = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Command, then data a cycle later; released data is inverted so a
  // stale word is never mistaken for a fresh one
  task automatic wr(input logic [7:0] c, input logic [HBC_DW-1:0] d);
    @(posedge clk_sys);
    cmdStrobe <= 1'b1;
    cmdCode <= c;
    @(posedge clk_sys);
    cmdStrobe <= 1'b0;
    dataWrStrobe <= 1'b1;
    dataWrValue <= d;
    @(posedge clk_sys);
    dataWrStrobe <= 1'b0;
    dataWrValue <= ~d;
  endtask
  // Answer is taken in the cycle after the command edge
  task automatic rd(input logic [7:0] c, output logic [HBC_DW-1:0] d,
                    output logic ok);
    @(posedge clk_sys);
    cmdStrobe <= 1'b1;
    cmdCode <= c;
    @(posedge clk_sys);
    cmdStrobe <= 1'b0;
    cmdCode <= ~c;
    #1;
    ok = rdValid_r;
    d = rdData_r;
  endtask
endmodule // hbc_host_model
`default_nettype wire
